// ### core/fifo_consts.vh
// constants for the dual-clock fifo flag logic, 4096 x 80 depth variant
// assumes includers run on core_clk with pins sampled through synchronizers
`ifndef FIFO_CONSTS_VH
`define FIFO_CONSTS_VH

`define DATA_W 80
`define PTR_W 13
`define ADR_W 12
`define OFS_W 12
`define DEPTH 13'h1000
`define SERIAL_LAST 5'h17
`define MODE_EDGE 2'h2
`define PRESET_LO 12'h008
`define PRESET_MID 12'h010
`define PRESET_HI 12'h040

`define AXI_AW 12
`define REG_STATUS 12'h000
`define REG_OFFSETS 12'h004
`define REG_CONTROL 12'h008
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 1'h1
`define STATUS_PAD 26'h0
`define OFFSET_PAD 4'h0
`define CONTROL_PAD 31'h0

`endif

// ### core/dual_clock_fifo_flag_logic.v
// dual-clock fifo core: storage, serial offset load, mode select and flags
// assumes both port clocks are far slower than core_clk so every edge is seen
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`include "fifo_consts.vh"

module dual_clock_fifo_flag_logic (
	input wire core_clk,
	input wire reset,
	input wire writeClock,
	input wire readClock,
	input wire fullResetN,
	input wire serialProgramSelectN,
	input wire offsetSelect0OrSerialBit,
	input wire offsetSelect1OrSerialStrobe,
	input wire endianOrTimingSelect,
	input wire writePortSelectN,
	input wire writeRequest,
	input wire readPortSelectN,
	input wire readRequest,
	input wire outputEnableN,
	input wire [`DATA_W-1:0] writeData,
	output wire [`DATA_W-1:0] readData,
	output wire readDataOe,
	output wire fullOrInputReady,
	output wire emptyOrOutputReady,
	output wire almostEmptyFlag,
	output wire almostFullFlag,
	input wire [`AXI_AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`AXI_AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready
);

	function [`PTR_W-1:0] fillCount;
		input [`PTR_W-1:0] wp;
		input [`PTR_W-1:0] rp;
		begin
			fillCount = wp - rp;
		end
	endfunction

	function regHit;
		input [`AXI_AW-1:0] addr;
		begin
			regHit = (addr == `REG_STATUS) || (addr == `REG_OFFSETS) ||
				(addr == `REG_CONTROL);
		end
	endfunction

	function [`OFS_W-1:0] presetFor;
		input fs1;
		input fs0;
		begin
			case ({fs1, fs0})
				2'h3: presetFor = `PRESET_HI;
				2'h2: presetFor = `PRESET_MID;
				default: presetFor = `PRESET_LO;
			endcase
		end
	endfunction

	// pin synchronizers, two stages each
	wire [11:0] pinRaw;
	reg [11:0] pinSync1_q;
	reg [11:0] pinSync2_q;
	reg [`DATA_W-1:0] dataSync1_q;
	reg [`DATA_W-1:0] dataSync2_q;
	wire wClk;
	wire rClk;
	wire mrN;
	wire spmN;
	wire sBit;
	wire sStrobe;
	wire timingSel;
	wire wSelN;
	wire wReq;
	wire rSelN;
	wire rReq;
	wire oeN;

	assign pinRaw = {writeClock, readClock, fullResetN, serialProgramSelectN,
		offsetSelect0OrSerialBit, offsetSelect1OrSerialStrobe,
		endianOrTimingSelect, writePortSelectN, writeRequest,
		readPortSelectN, readRequest, outputEnableN};
	assign {wClk, rClk, mrN, spmN, sBit, sStrobe, timingSel, wSelN, wReq,
		rSelN, rReq, oeN} = pinSync2_q;

	// input data is only sampled, never driven back
	always @(posedge core_clk) begin
		if (reset) begin
			pinSync1_q <= 12'h000;
			pinSync2_q <= 12'h000;
			dataSync1_q <= {`DATA_W{1'b0}};
			dataSync2_q <= {`DATA_W{1'b0}};
		end else begin
			pinSync1_q <= pinRaw;
			pinSync2_q <= pinSync1_q;
			dataSync1_q <= writeData;
			dataSync2_q <= dataSync1_q;
		end
	end

	reg wClkPrev_q;
	reg rClkPrev_q;
	reg mrNPrev_q;
	wire wEdge;
	wire rEdge;
	wire mrRelease;
	wire inReset;

	assign wEdge = wClk & ~wClkPrev_q;
	assign rEdge = rClk & ~rClkPrev_q;
	assign mrRelease = mrN & ~mrNPrev_q;
	assign inReset = reset | ~mrN;

	always @(posedge core_clk) begin
		if (reset) begin
			wClkPrev_q <= 1'b0;
			rClkPrev_q <= 1'b0;
			mrNPrev_q <= 1'b0;
		end else begin
			wClkPrev_q <= wClk;
			rClkPrev_q <= rClk;
			mrNPrev_q <= mrN;
		end
	end

	// offset programming and mode latch
	reg serialMode_q;
	reg progDone_q;
	reg [2*`OFS_W-1:0] serialShift_q;
	reg [4:0] serialCount_q;
	reg [`OFS_W-1:0] aeOffset_q;
	reg [`OFS_W-1:0] afOffset_q;
	reg [1:0] modeEdges_q;
	reg modeLatched_q;
	reg standardMode_q;
	wire [2*`OFS_W-1:0] shiftNext;
	wire [1:0] modeEdgesNext;
	wire modeLatchNow;

	assign shiftNext = {serialShift_q[2*`OFS_W-2:0], sBit};
	assign modeEdgesNext = modeEdges_q + 2'h1;
	assign modeLatchNow = wEdge & ~modeLatched_q &
		(modeEdgesNext == `MODE_EDGE);

	always @(posedge core_clk) begin
		if (reset) begin
			serialMode_q <= 1'b0;
			progDone_q <= 1'b0;
			serialShift_q <= {2*`OFS_W{1'b0}};
			serialCount_q <= 5'h00;
			aeOffset_q <= `PRESET_LO;
			afOffset_q <= `PRESET_LO;
		end else if (~mrN) begin
			progDone_q <= 1'b0;
			serialCount_q <= 5'h00;
		end else if (mrRelease) begin
			serialMode_q <= ~spmN & ~sBit & sStrobe;
			progDone_q <= ~(~spmN & ~sBit & sStrobe);
			if (spmN) begin
				aeOffset_q <= presetFor(sStrobe, sBit);
				afOffset_q <= presetFor(sStrobe, sBit);
			end
		end else if (serialMode_q && !progDone_q && wEdge && !sStrobe) begin
			serialShift_q <= shiftNext;
			serialCount_q <= serialCount_q + 5'h01;
			if (serialCount_q == `SERIAL_LAST) begin
				progDone_q <= 1'b1;
				afOffset_q <= shiftNext[2*`OFS_W-1:`OFS_W];
				aeOffset_q <= shiftNext[`OFS_W-1:0];
			end
		end
	end

	always @(posedge core_clk) begin
		if (inReset) begin
			modeEdges_q <= 2'h0;
			modeLatched_q <= 1'b0;
			standardMode_q <= 1'b0;
		end else if (wEdge && !modeLatched_q) begin
			modeEdges_q <= modeEdgesNext;
			if (modeLatchNow) begin
				modeLatched_q <= 1'b1;
				standardMode_q <= timingSel;
			end
		end
	end

	// storage and pointers
	reg [`DATA_W-1:0] mem [0:`DEPTH-1];
	reg [`PTR_W-1:0] wptr_q;
	reg [`PTR_W-1:0] rptr_q;
	reg [`PTR_W-1:0] rptrW1_q;
	reg [`PTR_W-1:0] wptrR1_q;
	reg [`PTR_W-1:0] wptrR2_q;
	reg ff_q;
	reg af_q;
	reg ef_q;
	reg ae_q;
	reg [`DATA_W-1:0] readData_q;
	reg readDataOe_q;
	reg ctrlEnable_q;

	wire wFire;
	wire [`PTR_W-1:0] wptrNext;
	wire [`PTR_W-1:0] wFill;
	wire ffGate;

	// writes need select, request and a free slot
	assign wFire = wEdge & ~wSelN & wReq & ff_q & ctrlEnable_q;
	assign wptrNext = wptr_q + {{`PTR_W-1{1'b0}}, wFire};
	assign wFill = fillCount(wptrNext, rptrW1_q);
	assign ffGate = progDone_q & (modeLatched_q | modeLatchNow);

	always @(posedge core_clk) begin
		if (wFire) begin
			mem[wptr_q[`ADR_W-1:0]] <= dataSync2_q;
		end
	end

	// write-clock side: read pointer copy is stage one, flag stage two
	always @(posedge core_clk) begin
		if (inReset) begin
			wptr_q <= {`PTR_W{1'b0}};
			rptrW1_q <= {`PTR_W{1'b0}};
			ff_q <= 1'b0;
			af_q <= 1'b1;
		end else if (wEdge) begin
			wptr_q <= wptrNext;
			rptrW1_q <= rptr_q;
			ff_q <= ffGate & (wFill != `DEPTH);
			af_q <= wFill < (`DEPTH - {1'b0, afOffset_q});
		end
	end

	wire rFire;
	wire wordWaiting;
	wire loadWord;
	wire [`PTR_W-1:0] rptrNext;
	wire [`PTR_W-1:0] rFill;

	// reads ignored while the flag is low
	assign rFire = rEdge & ~rSelN & ~oeN & rReq & ef_q & ctrlEnable_q &
		modeLatched_q;
	assign wordWaiting = wptrR2_q != rptr_q;
	assign loadWord = standardMode_q ? rFire :
		(rEdge & modeLatched_q & (~ef_q | rFire) & wordWaiting);
	assign rptrNext = rptr_q + {{`PTR_W-1{1'b0}}, loadWord};
	assign rFill = fillCount(wptrR1_q, rptrNext);

	// read-clock side: write pointer copies feed the flags
	always @(posedge core_clk) begin
		if (inReset) begin
			rptr_q <= {`PTR_W{1'b0}};
			wptrR1_q <= {`PTR_W{1'b0}};
			wptrR2_q <= {`PTR_W{1'b0}};
			ef_q <= 1'b0;
			ae_q <= 1'b0;
		end else if (rEdge) begin
			wptrR1_q <= wptr_q;
			wptrR2_q <= wptrR1_q;
			rptr_q <= rptrNext;
			if (standardMode_q) begin
				ef_q <= modeLatched_q & (rFill != {`PTR_W{1'b0}});
			end else begin
				ef_q <= loadWord | (ef_q & ~rFire);
			end
			ae_q <= rFill > {1'b0, aeOffset_q};
		end
	end

	// output register keeps its word unless a new one is loaded
	always @(posedge core_clk) begin
		if (reset) begin
			readData_q <= {`DATA_W{1'b0}};
			readDataOe_q <= 1'b0;
		end else begin
			readDataOe_q <= ~rSelN & ~oeN;
			if (loadWord && !inReset) begin
				readData_q <= mem[rptr_q[`ADR_W-1:0]];
			end
		end
	end

	assign readData = readData_q;
	assign readDataOe = readDataOe_q;
	assign fullOrInputReady = ff_q;
	assign emptyOrOutputReady = ef_q;
	assign almostEmptyFlag = ae_q;
	assign almostFullFlag = af_q;

	// axi4-lite slave
	reg awReady_q;
	reg wReady_q;
	reg awHeld_q;
	reg wHeld_q;
	reg [`AXI_AW-1:0] awAddr_q;
	reg [31:0] wData_q;
	reg [3:0] wStrb_q;
	reg bValid_q;
	reg [1:0] bResp_q;
	reg arReady_q;
	reg rValid_q;
	reg [31:0] rData_q;
	reg [1:0] rResp_q;
	reg [31:0] readMux;

	always @* begin
		case (s_axi_araddr)
			`REG_STATUS: readMux = {`STATUS_PAD, progDone_q, standardMode_q,
				af_q, ae_q, ff_q, ef_q};
			`REG_OFFSETS: readMux = {`OFFSET_PAD, afOffset_q, `OFFSET_PAD,
				aeOffset_q};
			`REG_CONTROL: readMux = {`CONTROL_PAD, ctrlEnable_q};
			default: readMux = 32'h00000000;
		endcase
	end

	always @(posedge core_clk) begin
		if (reset) begin
			awReady_q <= 1'b1;
			wReady_q <= 1'b1;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= {`AXI_AW{1'b0}};
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
			bValid_q <= 1'b0;
			bResp_q <= `RESP_OKAY;
			ctrlEnable_q <= `CTRL_RESET;
		end else begin
			if (s_axi_awvalid && awReady_q) begin
				awAddr_q <= s_axi_awaddr;
				awHeld_q <= 1'b1;
				awReady_q <= 1'b0;
			end
			if (s_axi_wvalid && wReady_q) begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
				wHeld_q <= 1'b1;
				wReady_q <= 1'b0;
			end
			if (awHeld_q && wHeld_q && !bValid_q) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				bValid_q <= 1'b1;
				bResp_q <= regHit(awAddr_q) ? `RESP_OKAY : `RESP_SLVERR;
				if (awAddr_q == `REG_CONTROL && wStrb_q[0]) begin
					ctrlEnable_q <= wData_q[`CTRL_ENABLE_BIT];
				end
			end
			if (bValid_q && s_axi_bready) begin
				bValid_q <= 1'b0;
				awReady_q <= 1'b1;
				wReady_q <= 1'b1;
			end
		end
	end

	always @(posedge core_clk) begin
		if (reset) begin
			arReady_q <= 1'b1;
			rValid_q <= 1'b0;
			rData_q <= 32'h00000000;
			rResp_q <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && arReady_q) begin
				arReady_q <= 1'b0;
				rValid_q <= 1'b1;
				rData_q <= readMux;
				rResp_q <= regHit(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rValid_q && s_axi_rready) begin
				rValid_q <= 1'b0;
				arReady_q <= 1'b1;
			end
		end
	end

	assign s_axi_awready = awReady_q;
	assign s_axi_wready = wReady_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;

endmodule

// ### verification/fifo_port_partner.sv
// free-running write and read port clocks, unrelated in phase
// assumes core_clk is far faster than either port clock
`timescale 1ns/10ps
module fifo_port_partner (
	input wire core_clk,
	output logic writeClock = 1'h0,
	output logic readClock = 1'h0
);
	logic [3:0] wCnt = 4'h0;
	logic [3:0] rCnt = 4'h5;
	always @(posedge core_clk) begin
		wCnt <= (wCnt == 4'h9) ? 4'h0 : wCnt + 4'h1;
		rCnt <= (rCnt == 4'hC) ? 4'h0 : rCnt + 4'h1;
		if (wCnt == 4'h9)
			writeClock <= ~writeClock;
		if (rCnt == 4'hC)
			readClock <= ~readClock;
	end
endmodule

// ### verification/fifo_flag_properties.sv
// checker on the fifo core's pins and register bus handshakes
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/10ps
`include "fifo_consts.vh"
module fifo_flag_checker (
	input wire core_clk,
	input wire reset,
	input wire writeClock,
	input wire readClock,
	input wire fullResetN,
	input wire readPortSelectN,
	input wire outputEnableN,
	input wire [`DATA_W-1:0] readData,
	input wire readDataOe,
	input wire fullOrInputReady,
	input wire emptyOrOutputReady,
	input wire almostEmptyFlag,
	input wire almostFullFlag,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff reset;
	sequence quietRd;
		(fullResetN && $stable(readClock))[*8];
	endsequence
	sequence quietWr;
		(fullResetN && $stable(writeClock))[*8];
	endsequence
	a_oe_follows: assert property (
		$stable({readPortSelectN, outputEnableN})[*6] |->
		readDataOe == (!readPortSelectN && !outputEnableN))
		else $error("read drive enable wrong");
	a_reset_flags: assert property (
		!fullResetN[*6] |-> !fullOrInputReady && !emptyOrOutputReady
		&& !almostEmptyFlag && almostFullFlag)
		else $error("flags wrong in full reset");
	a_rd_quiet: assert property (
		quietRd |=> $stable({emptyOrOutputReady, almostEmptyFlag}))
		else $error("read flag moved without read edge");
	a_wr_quiet: assert property (
		quietWr |=> $stable({fullOrInputReady, almostFullFlag}))
		else $error("write flag moved without write edge");
	a_data_load: assert property (
		$changed(readData) && !$past(emptyOrOutputReady) |->
		##[0:1] emptyOrOutputReady)
		else $error("output word changed while not ready");
	a_wr_resp: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_rd_resp: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_wr_block: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_rd_block: assert property (
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while response pending");
endmodule
bind dual_clock_fifo_flag_logic fifo_flag_checker i_chk (.*);

// ### verification/dual_clock_fifo_flag_logic_tb_top.sv
// self-checking bench for the dual-clock fifo core
// assumes the partner makes both port clocks
`timescale 1ns/10ps
`include "fifo_consts.vh"
module dual_clock_fifo_flag_logic_tb_top;
	logic core_clk = 0, reset = 1, fullResetN = 0;
	logic serialProgramSelectN = 1, offsetSelect0OrSerialBit = 0;
	logic offsetSelect1OrSerialStrobe = 1, endianOrTimingSelect = 1;
	logic writePortSelectN = 1, writeRequest = 0, readPortSelectN = 1;
	logic readRequest = 0, outputEnableN = 1, readDataOe;
	logic [79:0] writeData = 0, readData;
	logic [79:0] q [0:3];
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic fullOrInputReady, emptyOrOutputReady, almostEmptyFlag;
	logic almostFullFlag, writeClock, readClock;
	logic [15:0] seed = 16'h0002;
	localparam [23:0] SER = 24'hFFD002;
	integer errors = 0, totalChecks = 0, i;
	dual_clock_fifo_flag_logic i_dut (.*);
	fifo_port_partner i_partner (.*);
	always #4 core_clk = ~core_clk;
	function [15:0] nx(input [15:0] s);
		nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task finish_test;
		if (errors == 0 && totalChecks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string nm, input [79:0] got, input [79:0] exp);
		totalChecks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	task tmo(input stuck);
		if (stuck) begin
			errors++;
			finish_test;
		end
	endtask
	task ax(input w, input [11:0] a, input [31:0] d);
		integer n;
		logic busy;
		// one edge between transfers, so no signal is driven twice
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		busy = 1;
		for (n = 0; n < 400 && busy; n++) begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 0;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 0;
			if (s_axi_bready && s_axi_bvalid) begin
				s_axi_bready <= 0;
				rs = s_axi_bresp;
				busy = 0;
			end
			if (s_axi_rready && s_axi_rvalid) begin
				s_axi_rready <= 0;
				rs = s_axi_rresp;
				rd = s_axi_rdata;
				busy = 0;
			end
		end
		tmo(busy);
	endtask
	// returns at the core edge after a port clock falls, bounded
	task cn(input sel);
		integer n;
		logic prev;
		prev = sel ? readClock : writeClock;
		for (n = 0; n < 400; n++) begin
			@(posedge core_clk);
			if (prev && !(sel ? readClock : writeClock))
				break;
			prev = sel ? readClock : writeClock;
		end
		tmo(n >= 400);
	endtask
	task wn;
		cn(0);
	endtask
	task rn;
		cn(1);
	endtask
	task pw(input [79:0] v);
		wn;
		writeData <= v;
		writePortSelectN <= 0;
		writeRequest <= 1;
		wn;
		writeRequest <= 0;
		writeData <= ~v;
	endtask
	task pr;
		rn;
		readRequest <= 1;
		rn;
		readRequest <= 0;
	endtask
	task wef;
		integer n;
		for (n = 0; n < 400 && emptyOrOutputReady !== 1; n++)
			@(posedge core_clk);
		tmo(emptyOrOutputReady !== 1'b1);
		chk("ef", emptyOrOutputReady, 1);
	endtask
	task fr(input m, input s, input f1, input f0);
		fullResetN <= 0;
		endianOrTimingSelect <= m;
		serialProgramSelectN <= s;
		offsetSelect1OrSerialStrobe <= f1;
		offsetSelect0OrSerialBit <= f0;
		repeat (120) @(posedge core_clk);
		chk("flags", {fullOrInputReady, emptyOrOutputReady,
			almostEmptyFlag, almostFullFlag}, 4'h1);
		fullResetN <= 1;
		repeat (100) @(posedge core_clk);
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 0;
		fr(1, 0, 1, 0);
		for (i = 0; i < 24; i++) begin
			wn;
			offsetSelect0OrSerialBit <= SER[23 - i];
			offsetSelect1OrSerialStrobe <= 0;
		end
		wn;
		offsetSelect1OrSerialStrobe <= 1;
		chk("ir", fullOrInputReady, 0);
		repeat (30) @(posedge core_clk);
		chk("ir", fullOrInputReady, 1);
		ax(0, 12'h004, 0);
		chk("ofs", rd, 32'h0FFD0002);
		ax(0, 12'h000, 0);
		chk("mode", rd[5:4], 2'h3);
		ax(0, 12'h00C, 0);
		chk("resp", rs, 2'h2);
		for (i = 0; i < 4; i++) begin
			seed = nx(seed);
			q[i] = {5{seed}};
			pw(q[i]);
			if (i == 1) begin
				repeat (80) @(posedge core_clk);
				chk("ae", almostEmptyFlag, 0);
				chk("af", almostFullFlag, 1);
			end
		end
		wef;
		repeat (80) @(posedge core_clk);
		chk("ae", almostEmptyFlag, 1);
		chk("af", almostFullFlag, 0);
		chk("rd", readData, 0);
		outputEnableN <= 0;
		readPortSelectN <= 0;
		for (i = 0; i < 4; i++) begin
			pr;
			chk("rd", readData, q[i]);
		end
		repeat (60) @(posedge core_clk);
		chk("ef", emptyOrOutputReady, 0);
		chk("af", almostFullFlag, 1);
		chk("ae", almostEmptyFlag, 0);
		pr;
		chk("rd", readData, q[3]);
		ax(1, 12'h008, 0);
		chk("bresp", rs, 2'h0);
		pw(q[0]);
		repeat (80) @(posedge core_clk);
		chk("ef", emptyOrOutputReady, 0);
		ax(1, 12'h008, 1);
		fr(0, 1, 0, 1);
		ax(0, 12'h004, 0);
		chk("ofs", rd, 32'h00080008);
		ax(0, 12'h000, 0);
		chk("mode", rd[5:4], 2'h2);
		pw(q[1]);
		wef;
		chk("rd", readData, q[1]);
		pw(q[2]);
		repeat (80) @(posedge core_clk);
		chk("rd", readData, q[1]);
		pr;
		chk("rd", readData, q[2]);
		fr(1, 1, 1, 1);
		ax(0, 12'h004, 0);
		chk("ofs", rd, 32'h00400040);
		ax(0, 12'h000, 0);
		chk("mode", rd[5:4], 2'h3);
		finish_test;
	end
endmodule
